// [rtl/tsf_pkg.sv]
// Constants and types shared by the tilt sensor output filter
`default_nettype none

package tsf_pkg;

  localparam int unsigned DATA_W   = 16;
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned NUM_CH   = 8;
  localparam int unsigned FACTOR_W = 4;
  localparam int unsigned CNT_W    = 11;
  localparam int unsigned ACC_W    = 28;

  // Register addresses as carried in request bits 14:8
  localparam logic [6:0] ADDR_SUPPLY  = 7'h02;
  localparam logic [6:0] ADDR_X_ACCEL = 7'h04;
  localparam logic [6:0] ADDR_Y_ACCEL = 7'h06;
  localparam logic [6:0] ADDR_Z_ACCEL = 7'h08;
  localparam logic [6:0] ADDR_TEMP    = 7'h0A;
  localparam logic [6:0] ADDR_X_TILT  = 7'h0C;
  localparam logic [6:0] ADDR_Y_TILT  = 7'h0E;
  localparam logic [6:0] ADDR_Z_TILT  = 7'h10;
  localparam logic [6:0] ADDR_AVG_LO  = 7'h38;
  localparam logic [6:0] ADDR_AVG_HI  = 7'h39;

  // Result channels follow address order, two bytes apart
  localparam logic [6:0] ADDR_FIRST_RESULT = ADDR_SUPPLY;
  localparam logic [6:0] ADDR_LAST_RESULT  = ADDR_Z_TILT;

  // Average factor field and reset value
  localparam logic [3:0]  FACTOR_RST      = 4'h9;
  localparam logic [3:0]  FACTOR_MAX      = 4'hB;
  localparam logic [3:0]  FACTOR_FULL_RES = 4'h4;
  localparam logic [15:0] RESULT_RST      = 16'h0000;
  localparam logic [15:0] FULL_MASK       = 16'hFFFF;

  // Channels that hold two's complement data (accel and tilt)
  localparam logic [7:0] CH_SIGNED = 8'hEE;

  // Scaling of the result codes
  localparam int ACCEL_LSB_PER_G    = 16384;
  localparam int TILT_LSB_PER_180   = 32768;
  localparam int SUPPLY_LSB_PER_5V  = 32768;
  localparam logic [15:0] TEMP_25C_CODE = 16'h04FE;
  localparam int SAMPLE_RATE_HZ     = 512;

  // Raw sample set, supply in the lowest sixteen bits
  typedef struct packed {
    logic [15:0] z_tilt;
    logic [15:0] y_tilt;
    logic [15:0] x_tilt;
    logic [15:0] temp;
    logic [15:0] z_acc;
    logic [15:0] y_acc;
    logic [15:0] x_acc;
    logic [15:0] supply;
  } tsf_raw_t;

  // Serial request word
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } tsf_req_t;

  typedef enum logic [2:0] {
    CMD_IDLE   = 3'b001,
    CMD_DECODE = 3'b010,
    CMD_REPLY  = 3'b100
  } tsf_cmd_state_t;

endpackage

`default_nettype wire

// [rtl/tsf_top.sv]
// Output registers, averaging filter and serial slave port
`default_nettype none

// What this block does
// - Accel results: signed, 16384 counts per g
// - Tilt results: signed, 180/32768 degree steps
// - Temperature unsigned, 0x04FE at 25 C
// - Supply unsigned, 5/32768 volt steps
// - Average depth is two to the factor
// - Update rate is 512 over depth
// - Factor resets to 9, upper bits unused
// - Result registers ignore host writes
// - Read: request frame, data next frame
// - Drive data only after read request
// - Factor below 4: accel and tilt keep factor plus 12 bits

module tsf_top
  import tsf_pkg::*;
#(
  parameter logic [3:0] FACTOR_DEFAULT = FACTOR_RST
) (
  input  wire logic     MCLK_I,
  input  wire logic     RESETN_I,
  input  wire logic     CE_I,
  input  wire logic     SMPL_STB_I,
  input  wire tsf_raw_t SMPL_I,
  input  wire logic     SCLK_I,
  input  wire logic     CS_N_I,
  input  wire logic     DIN_I,
  output logic          DOUT_O,
  output logic          DOUT_OE_O,
  output logic          DATA_RDY_O
);

  // ------------------------------------------------------------
  // Link side, clocked by the serial clock
  // ------------------------------------------------------------

  logic [3:0]  bit_cnt;
  logic [14:0] rx_shift;
  tsf_req_t    rx_word;
  logic        rx_tgl;
  logic [15:0] tx_shift;
  logic        tx_loaded;

  // Reply word and its enable live in the main domain
  logic [15:0] reply_word;

  // Chip select high clears the frame without needing a clock edge
  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Mode 3: input is sampled on the rising edge, MSB first
  always_ff @(posedge SCLK_I) begin
    rx_shift <= {rx_shift[13:0], DIN_I};
  end

  // Whole request word captured on the sixteenth rising edge
  always_ff @(posedge SCLK_I) begin
    if (!CS_N_I && bit_cnt == 4'hF) begin
      rx_word <= {rx_shift, DIN_I};
    end
  end

  // Event toggle toward the main domain; the serial clock may stand
  // still outside frames, so only the main reset can define it
  always_ff @(posedge SCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_tgl <= 1'b0;
    end else if (!CS_N_I && bit_cnt == 4'hF) begin
      rx_tgl <= ~rx_tgl;
    end
  end

  // First falling edge of a frame loads the reply, later ones shift.
  // The reply word changes only between frames, so it is sampled
  // here as a quasi-static word.
  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      tx_loaded <= 1'b0;
      tx_shift  <= RESULT_RST;
    end else if (!tx_loaded) begin
      tx_loaded <= 1'b1;
      tx_shift  <= reply_word;
    end else begin
      tx_shift  <= {tx_shift[14:0], 1'b0};
    end
  end

  assign DOUT_O = tx_shift[15];

  // ------------------------------------------------------------
  // Crossing into the main clock
  // ------------------------------------------------------------

  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic req_seen;
  logic cs_fall;
  logic cs_rise;

  // Chip select idles high, so its stages reset to the idle level and
  // no false frame edge follows reset
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_s3  <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else if (CE_I) begin
      cs_s1  <= CS_N_I;
      cs_s2  <= cs_s1;
      cs_s3  <= cs_s2;
      tgl_s1 <= rx_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // Edges come from the second and third stages only
  assign req_seen = tgl_s2 ^ tgl_s3;
  assign cs_fall  = cs_s3 & ~cs_s2;
  assign cs_rise  = cs_s2 & ~cs_s3;

  // ------------------------------------------------------------
  // Average factor and filter
  // ------------------------------------------------------------

  logic [3:0]       factor;
  logic             factor_wr;
  logic [3:0]       factor_new;
  logic [CNT_W-1:0] smp_cnt;
  logic [CNT_W-1:0] smp_last;
  logic             out_now;
  logic             smp_stb_ok;
  logic [15:0]      trim_mask;
  logic [15:0]      result [NUM_CH];

  // A strobe counts only while the clock enable lets state move
  assign smp_stb_ok = SMPL_STB_I & CE_I;

  // Depth minus one: 2**factor samples per output
  assign smp_last =
    CNT_W'((12'h001 << factor) - 12'h001);
  assign out_now  = smp_stb_ok & (smp_cnt == smp_last);

  // Clear low bits that carry no resolution at shallow averaging
  assign trim_mask = (factor < FACTOR_FULL_RES) ?
    (FULL_MASK << (FACTOR_FULL_RES - factor)) : FULL_MASK;

  // Writes above the top factor are clamped, so the sample counter
  // never needs more than CNT_W bits
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      factor <= FACTOR_DEFAULT;
    end else if (CE_I && factor_wr) begin
      factor <= factor_new;
    end
  end

  // Sample counter restarts whenever the factor changes, so a new
  // depth never mixes with a partial sum from the old one
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      smp_cnt <= '0;
    end else if (CE_I) begin
      if (factor_wr) begin
        smp_cnt <= '0;
      end else if (out_now) begin
        smp_cnt <= '0;
      end else if (SMPL_STB_I) begin
        smp_cnt <= smp_cnt + CNT_W'(1);
      end
    end
  end

  // One accumulator per channel; 28 bits hold 2048 full-scale
  // unsigned samples, the deepest average, without overflow
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    logic                    sbit;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] ext;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] avg;
    logic [15:0]             raw;
    logic [15:0]             mask;

    assign raw  = SMPL_I[ch*DATA_W +: DATA_W];
    // Accel and tilt extend the sign, temp and supply do not
    assign sbit = CH_SIGNED[ch] & raw[15];
    assign ext  = {{(ACC_W - DATA_W){sbit}}, raw};
    assign sum  = acc + ext;
    assign avg  = sum >>> factor;
    assign mask = CH_SIGNED[ch] ? trim_mask : FULL_MASK;

    always_ff @(posedge MCLK_I) begin
      if (!RESETN_I) begin
        acc <= '0;
      end else if (CE_I) begin
        if (factor_wr || out_now) begin
          acc <= '0;
        end else if (SMPL_STB_I) begin
          acc <= sum;
        end
      end
    end

    // Every channel loads on the same strobe
    // A load is skipped in the cycle of a factor write
    always_ff @(posedge MCLK_I) begin
      if (!RESETN_I) begin
        result[ch] <= RESULT_RST;
      end else if (out_now && !factor_wr) begin
        result[ch] <= avg[15:0] & mask;
      end
    end
  end

  // Pulse marking fresh results, one enabled cycle per output; it holds while CE_I is low
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      DATA_RDY_O <= 1'b0;
    end else if (CE_I) begin
      DATA_RDY_O <= out_now & ~factor_wr;
    end
  end

  // ------------------------------------------------------------
  // Request handling
  // ------------------------------------------------------------

  tsf_cmd_state_t state;
  tsf_req_t       req;
  logic [15:0]    read_val;
  logic           reply_en;
  logic [2:0]     ch_idx;
  logic           is_result;
  logic [6:0]     addr_off;

  // Requests are a frame apart, far longer than these three steps,
  // so a request never arrives while the machine is busy
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      state <= CMD_IDLE;
    end else if (CE_I) begin
      unique case (state)
        CMD_IDLE: begin
          if (req_seen) begin
            state <= CMD_DECODE;
          end
        end
        CMD_DECODE: begin
          state <= CMD_REPLY;
        end
        CMD_REPLY: begin
          state <= CMD_IDLE;
        end
      endcase
    end
  end

  // The link word stays put until the sixteenth rising edge of the next frame
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      req <= '0;
    end else if (CE_I && state == CMD_IDLE && req_seen) begin
      req <= rx_word;
    end
  end

  // Result channel from address: supply at 0x02, two bytes apart
  assign addr_off  = req.addr - ADDR_FIRST_RESULT;
  assign ch_idx    = addr_off[3:1];
  assign is_result = !req.addr[0]
                   && req.addr >= ADDR_FIRST_RESULT
                   && req.addr <= ADDR_LAST_RESULT;

  // Odd and unmapped addresses read back as zero
  always_comb begin
    if (is_result) begin
      read_val = result[ch_idx];
    end else if (req.addr == ADDR_AVG_LO) begin
      read_val = {12'h000, factor};
    end else begin
      read_val = RESULT_RST;
    end
  end

  // Only the low byte of the factor register takes a write; the
  // result addresses have no write path at all
  assign factor_wr = (state == CMD_DECODE) && req.write
                   && (req.addr == ADDR_AVG_LO);
  assign factor_new = (req.data[3:0] > FACTOR_MAX) ?
                      FACTOR_MAX : req.data[3:0];

  // After a write the old reply word stays, but the next frame keeps
  // the pin released
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      reply_word <= RESULT_RST;
      reply_en   <= 1'b0;
    end else if (CE_I && state == CMD_DECODE) begin
      reply_en   <= ~req.write;
      if (!req.write) begin
        reply_word <= read_val;
      end
    end
  end

  // Output enable follows the frame; it is decided at frame start
  // so a reply arriving mid-frame cannot switch the pin
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      DOUT_OE_O <= 1'b0;
    end else if (CE_I) begin
      if (cs_rise || cs_s2) begin
        DOUT_OE_O <= 1'b0;
      end else if (cs_fall) begin
        DOUT_OE_O <= reply_en;
      end
    end
  end

endmodule

`default_nettype wire

// [sim/tsf_monitor.sv]
// Port checker for the tilt sensor output filter
`default_nettype none

module tsf_monitor (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic SMPL_STB_I,
  input wire logic CS_N_I,
  input wire logic DOUT_O,
  input wire logic DOUT_OE_O,
  input wire logic DATA_RDY_O
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);

  a_rdy_one_cycle: assert property (
    DATA_RDY_O && CE_I && !SMPL_STB_I |=> !DATA_RDY_O)
    else $error("ready pulse longer than one cycle");
  a_rdy_from_strobe: assert property (
    DATA_RDY_O && $past(CE_I) |-> $past(SMPL_STB_I))
    else $error("ready without a strobe one cycle before");
  a_rdy_after_reset: assert property (DATA_RDY_O |-> $past(RESETN_I))
    else $error("ready right after reset");
  a_oe_off_idle: assert property (CS_N_I [*4] |-> !DOUT_OE_O)
    else $error("output enabled while deselected");
  a_dout_idle_low: assert property (CS_N_I [*2] |-> !DOUT_O)
    else $error("data out not low while deselected");
  a_oe_needs_cs: assert property ($rose(DOUT_OE_O) |-> $past(!CS_N_I, 3))
    else $error("output enable rose too early");
  a_oe_holds: assert property (!CS_N_I && DOUT_OE_O |=> DOUT_OE_O)
    else $error("output enable dropped inside frame");
  a_oe_late_start: assert property (
    $fell(CS_N_I) |-> !DOUT_OE_O ##1 !DOUT_OE_O ##1 !DOUT_OE_O)
    else $error("output enable before its delay");

  c_ready: cover property (DATA_RDY_O);
  c_oe_on: cover property ($rose(DOUT_OE_O));
  c_oe_off: cover property ($rose(CS_N_I) && DOUT_OE_O);
endmodule

`default_nettype wire

// [sim/tsf_host.sv]
// Serial master model standing in for the host processor
`default_nettype none

module tsf_host (
  input  wire logic dout_i,
  input  wire logic oe_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic last;
  logic oe_seen;

  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    last = 1'b0;
    oe_seen = 1'b0;
  end

  // Mode 3 frame, MSB first; the reply belongs to the previous request
  task automatic xfer(input logic [15:0] req, output logic [15:0] rsp);
    #3.3;
    oe_seen = 1'b0;
    cs_n_o = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      din_o = req[i];
      #16;
      sclk_o = 1'b1;
      // A released line does not keep its last level
      last = oe_i ? dout_i : ~last;
      rsp[i] = last;
      oe_seen = oe_seen | oe_i;
      #16;
    end
    cs_n_o = 1'b1;
    din_o = ~din_o;
    // Gap lets the request cross before the next frame
    #200;
  endtask
endmodule

`default_nettype wire

// [sim/tsf_top_bench.sv]
// Self-checking bench for the tilt sensor output filter
`default_nettype none

module tsf_top_bench
  import tsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic     mclk = 1'b0;
  logic     resetn = 1'b0;
  logic     ce = 1'b1;
  logic     stb = 1'b0;
  tsf_raw_t raw = '0;
  logic     sclk;
  logic     cs_n;
  logic     din;
  logic     dout;
  logic     oe;
  logic     rdy;
  int       miscompares = 0;
  int       n_tests = 0;
  int       rdy_cnt = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (rdy === 1'b1) rdy_cnt++;

  tsf_top tsf_top_i (
    .MCLK_I(mclk), .RESETN_I(resetn), .CE_I(ce), .SMPL_STB_I(stb),
    .SMPL_I(raw), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din),
    .DOUT_O(dout), .DOUT_OE_O(oe), .DATA_RDY_O(rdy));
  tsf_host tsf_host_i (
    .dout_i(dout), .oe_i(oe), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  task automatic end_of_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_tests++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic [15:0] d;
    tsf_host_i.xfer({1'b0, a, 8'h00}, d);
    tsf_host_i.xfer(16'h0000, v);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] b);
    logic [15:0] d;
    tsf_host_i.xfer({1'b1, a, b}, d);
  endtask

  task automatic strobe(input tsf_raw_t v);
    @(posedge mclk);
    #1;
    stb = 1'b1;
    raw = v;
    @(posedge mclk);
    #1;
    stb = 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic s_reset();
    logic [15:0] v;
    rd(ADDR_AVG_LO, v);
    chk(v, 16'h0009);
    rd(ADDR_TEMP, v);
    chk(v, 16'h0000);
  endtask

  task automatic s_single();
    logic [15:0] v;
    logic [15:0] want [8] = '{16'h547B, 16'h4000, 16'hC000, 16'h6CC0,
                              16'h04FE, 16'h8000, 16'h7FF0, 16'h0000};
    int n;
    wr(ADDR_AVG_LO, 8'h00);
    rd(ADDR_AVG_LO, v);
    chk(v, 16'h0000);
    n = rdy_cnt;
    strobe({16'h0002, 16'h7FFF, 16'h8000, 16'h04FE,
            16'h6CCD, 16'hC000, 16'h4000, 16'h547B});
    chk(16'(rdy_cnt - n), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      rd(7'(ADDR_SUPPLY + 2 * i), v);
      chk(v, want[i]);
    end
  endtask

  task automatic s_ro_write();
    logic [15:0] v;
    wr(ADDR_X_ACCEL, 8'h12);
    tsf_host_i.xfer(16'h0400, v);
    chk({15'h0000, tsf_host_i.oe_seen}, 16'h0000);
    tsf_host_i.xfer(16'h0000, v);
    chk({15'h0000, tsf_host_i.oe_seen}, 16'h0001);
    chk(v, 16'h4000);
  endtask

  task automatic s_average();
    logic [15:0] v;
    int n;
    wr(ADDR_AVG_LO, 8'h02);
    n = rdy_cnt;
    for (int k = 0; k < 4; k++) begin
      if (k == 3) chk(16'(rdy_cnt - n), 16'h0000);
      strobe({8{16'(16'hFFFF - k)}});
    end
    chk(16'(rdy_cnt - n), 16'h0001);
    rd(ADDR_SUPPLY, v);
    chk(v, 16'hFFFD);
    rd(ADDR_TEMP, v);
    chk(v, 16'hFFFD);
    rd(ADDR_Y_TILT, v);
    chk(v, 16'hFFFC);
  endtask

  // Oversized factor clamps; a strobe under a low enable changes nothing
  task automatic s_clamp_freeze();
    logic [15:0] v;
    int n;
    wr(ADDR_AVG_LO, 8'h0F);
    rd(ADDR_AVG_LO, v);
    chk(v, 16'h000B);
    wr(ADDR_AVG_LO, 8'h00);
    n = rdy_cnt;
    @(posedge mclk);
    #1;
    ce = 1'b0;
    strobe({8{16'h1234}});
    chk(16'(rdy_cnt - n), 16'h0000);
    @(posedge mclk);
    #1;
    ce = 1'b1;
    rd(ADDR_SUPPLY, v);
    chk(v, 16'hFFFD);
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge mclk);
    s_reset();
    s_single();
    s_ro_write();
    s_average();
    s_clamp_freeze();
    end_of_test();
  end

  // About forty frames fit well inside this span
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule

bind tsf_top tsf_monitor tsf_monitor_i (
  .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .CE_I(CE_I),
  .SMPL_STB_I(SMPL_STB_I), .CS_N_I(CS_N_I), .DOUT_O(DOUT_O),
  .DOUT_OE_O(DOUT_OE_O), .DATA_RDY_O(DATA_RDY_O));

`default_nettype wire
